// [rtl/cse_pkg.sv]
/*
  Package for the CAN channel status and error-reporting block: register
  offset, bit positions, reset values, error codes and recovery counts.
  Assumes a single 125 MHz system clock domain.
*/
package cse_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] STATUS_REG_OFFSET = 8'he4;
  localparam logic [7:0] STATUS_REG_RESET = 8'h00;
  localparam int BIT_BUS_OFF = 7;
  localparam int BIT_ECE = 6;
  localparam int BIT_WAKE = 5;
  localparam int BIT_RXS = 4;
  localparam int BIT_TXS = 3;

  // ----------------------------------------------------------------------
  // bus error codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_STUFF = 3'h1;
  localparam logic [2:0] ERR_FORMAT = 3'h2;
  localparam logic [2:0] ERR_NOACK = 3'h3;
  localparam logic [2:0] ERR_BIT1 = 3'h4;
  localparam logic [2:0] ERR_BIT0 = 3'h5;
  localparam logic [2:0] ERR_CRC = 3'h6;
  localparam logic [2:0] ERR_NO_CHANGE = 3'h7;

  // ----------------------------------------------------------------------
  // limits and counts
  // ----------------------------------------------------------------------
  localparam logic [8:0] ECE_LIMIT_LOW = 9'h060;
  localparam logic [8:0] ECE_LIMIT_HIGH = 9'h080;
  localparam logic [8:0] TX_BUS_OFF_COUNT = 9'h100;
  localparam logic [3:0] RECESSIVE_RUN = 4'hb;
  localparam logic [7:0] RECOVERY_RUNS = 8'h80;
  localparam int STUFF_RUN_MAX = 5;
  localparam logic [7:0] IRQ_SRC_NONE = 8'h00;
  localparam logic [7:0] IRQ_SRC_STATUS = 8'h01;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic bit0_err;
    logic stuff_err;
    logic crc_err;
    logic noack_err;
    logic format_err;
    logic bit1_err;
  } cse_err_type;

  typedef struct packed {
    logic global_irq_enable;
    logic channel_irq_enable;
    logic error_irq_enable;
    logic status_irq_enable;
    logic error_limit_select;
    logic autobaud_mode;
    logic power_down_enable;
    logic sleep_mode;
  } cse_ctrl_type;

  typedef struct packed {
    logic bit_tick;
    logic rx_bit;
    logic tx_bit;
    logic tx_active;
    logic rx_in_frame;
    logic in_arbitration;
  } cse_bus_type;

  typedef enum logic [1:0] {
    CSE_ACTIVE,
    CSE_RECOVERY,
    CSE_POWER_UP,
    CSE_INIT
  } cse_mode_type;

endpackage : cse_pkg

// [rtl/cse_bit_checker.sv]
/*
  Bit-level error detector: stuff-run counting and transmit/receive bit
  compare, one result per bit-time enable pulse.
  Assumes bus samples are already synchronised to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module cse_bit_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clr,
  input wire cse_pkg::cse_bus_type bus,
  output logic stuff_err,
  output logic bit1_err,
  output logic bit0_err
);

  typedef struct packed {
    logic [2:0] run;
    logic last;
    logic stuff;
    logic b1;
    logic b0;
  } cse_chk_type;

  cse_chk_type st_ff;
  cse_chk_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stuff = 1'b0;
    nxt_st.b1 = 1'b0;
    nxt_st.b0 = 1'b0;
    if (clr || !bus.rx_in_frame) begin
      nxt_st.run = 3'h0;
    end else if (bus.bit_tick) begin
      if (bus.rx_bit == st_ff.last && st_ff.run != 3'h0) begin
        nxt_st.run = (st_ff.run == 3'h7) ? 3'h7 : 3'(st_ff.run + 3'h1);
        // sixth equal bit in a row breaks the stuffing rule
        nxt_st.stuff = (st_ff.run == 3'(cse_pkg::STUFF_RUN_MAX)); // RL20
      end else begin
        nxt_st.run = 3'h1;
      end
      nxt_st.last = bus.rx_bit;
    end
    // arbitration losses are normal, so compare only outside it
    if (!clr && bus.bit_tick && bus.tx_active && !bus.in_arbitration) begin
      nxt_st.b1 = bus.tx_bit && !bus.rx_bit; // RL21
      nxt_st.b0 = !bus.tx_bit && bus.rx_bit; // RL21
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stuff_err = st_ff.stuff;
  assign bit1_err = st_ff.b1;
  assign bit0_err = st_ff.b0;

  chk_bit_compare: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL21
    (bus.bit_tick && bus.in_arbitration && !clr) |=> !(bit1_err || bit0_err))
    else $error("bit error flagged inside arbitration");

endmodule : cse_bit_checker

`default_nettype wire

// [rtl/cse_status_unit.sv]
/*
  Status register of one CAN channel: bus-off entry and recovery, error
  count exceeded flag, sticky rx/tx success flags, locked bus error code
  and the status-change interrupt source indicator.
  Assumes the CPU register port and bus sample inputs live on clk_sys and
  that the caller gives one bit_tick pulse per CAN bit time.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1 - bus-off clears only after 128x11 recessive runs then 11 more
// RL2 - leaving bus-off sets sw init enable; bus resumes once software clears it
// RL3 - bus-off rising raises channel interrupt with error, channel, global enables
// RL4 - cpu writes to sw init enable are ignored while bus-off
// RL5 - leaving bus-off zeroes both error counters
// RL6 - exceeded flag follows either counter at 96 or 128 per select bit
// RL7 - with 128 limit, both edges of exceeded flag raise interrupt
// RL8 - rx success set by logic, cleared by write, soft reset or reset
// RL9 - autobaud off: rx success needs error-free reception and store
// RL10 - autobaud on: any error-free reception sets rx success
// RL11 - rising rx or tx success with status enable shows source 01h
// RL12 - any status read clears pending status interrupt, indicator drops
// RL13 - each new reception re-raises status interrupt after a read
// RL14 - software 0-to-1 flag write raises artificial interrupt; 1-to-1 none
// RL15 - tx success set after acked clean transmit, cleared like rx
// RL16 - status read with init disabled forces code to 111b; code read only
// RL17 - new code loads only over 000b or 111b, else dropped silently
// RL18 - simultaneous errors: keep highest priority, bit-0 first, bit-1 last
// RL19 - code values: stuff 1, format 2, noack 3, bit1 4, bit0 5, crc 6
// RL20 - more than five equal received bits flag a stuff error
// RL21 - bit-0 and bit-1 compare errors never inside arbitration
// RL22 - each recessive bit during recovery records a bit-0 error
// RL23 - wake status is power-down enable or sleep mode
// RL24 - code change to real error interrupts with status and channel enables
// RL25 - tx counter reaching 256 sets bus-off and stops bus activity
module cse_status_unit (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic channel_soft_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sw_init_wr,
  input wire logic sw_init_wdata,
  output logic sw_init_enable,
  input wire cse_pkg::cse_ctrl_type ctrl,
  input wire cse_pkg::cse_bus_type bus_pin,
  input wire cse_pkg::cse_err_type frame_err,
  input wire logic rx_ok,
  input wire logic rx_stored,
  input wire logic tx_ok_acked,
  input wire logic [8:0] tx_err_count,
  input wire logic [7:0] rx_err_count,
  output logic err_count_clear,
  output logic bus_enable,
  input wire logic [7:0] msg_irq_source,
  output logic [7:0] irq_source_indicator,
  output logic can_irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    cse_pkg::cse_mode_type mode;
    logic bus_off;
    logic ece;
    logic rx_success_flag;
    logic tx_success_flag;
    logic [2:0] code;
    logic sw_init;
    logic [3:0] run_cnt;
    logic [7:0] rec_cnt;
    logic stat_pend;
    logic err_pend;
    logic cnt_clr;
    logic [7:0] rdata;
  } cse_state_type;

  cse_state_type st_ff;
  cse_state_type nxt_st;
  cse_pkg::cse_bus_type bus_m_ff;
  cse_pkg::cse_bus_type bus_s_ff;
  logic stuff_err;
  logic bit1_err;
  logic bit0_err;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [2:0] pick_code(input cse_pkg::cse_err_type e);
    logic [2:0] c;
    c = cse_pkg::ERR_NONE;
    if (e.bit0_err) begin // RL18
      c = cse_pkg::ERR_BIT0; // RL19
    end else if (e.stuff_err) begin
      c = cse_pkg::ERR_STUFF;
    end else if (e.crc_err) begin
      c = cse_pkg::ERR_CRC;
    end else if (e.noack_err) begin
      c = cse_pkg::ERR_NOACK;
    end else if (e.format_err) begin
      c = cse_pkg::ERR_FORMAT;
    end else if (e.bit1_err) begin
      c = cse_pkg::ERR_BIT1;
    end
    return c;
  endfunction

  function automatic logic over_limit(input logic [8:0] tec, input logic [7:0] rec, input logic sel);
    logic [8:0] lim;
    lim = sel ? cse_pkg::ECE_LIMIT_HIGH : cse_pkg::ECE_LIMIT_LOW;
    return (tec >= lim) || ({1'b0, rec} >= lim); // RL6
  endfunction

  // ----------------------------------------------------------------------
  // pin synchroniser: two flops before any logic reads the bus samples
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_m_ff <= '0;
      bus_s_ff <= '0;
    end else begin
      bus_m_ff <= bus_pin;
      bus_s_ff <= bus_m_ff;
    end
  end

  cse_bit_checker u_bit_checker (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clr(st_ff.bus_off),
    .bus(bus_s_ff),
    .stuff_err(stuff_err),
    .bit1_err(bit1_err),
    .bit0_err(bit0_err)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic status_hit;
  logic status_rd;
  logic status_wr;
  logic ece_now;
  logic rx_event;
  logic tx_event;
  logic err_irq_on;
  logic recessive_bit;
  cse_pkg::cse_err_type all_err;
  logic [2:0] new_code;

  always_comb begin
    status_hit = (reg_addr == cse_pkg::STATUS_REG_OFFSET);
    status_rd = status_hit && reg_rd;
    status_wr = status_hit && reg_wr;
    err_irq_on = ctrl.error_irq_enable && ctrl.channel_irq_enable && ctrl.global_irq_enable;
    recessive_bit = bus_s_ff.bit_tick && bus_s_ff.rx_bit;
    ece_now = over_limit(tx_err_count, rx_err_count, ctrl.error_limit_select);
    rx_event = rx_ok && (ctrl.autobaud_mode || rx_stored); // RL9 RL10
    tx_event = tx_ok_acked; // RL15
    all_err = frame_err;
    all_err.stuff_err = frame_err.stuff_err || stuff_err; // RL20
    all_err.bit1_err = frame_err.bit1_err || bit1_err; // RL21
    all_err.bit0_err = frame_err.bit0_err || bit0_err;
    nxt_st = st_ff;
    nxt_st.cnt_clr = 1'b0;
    nxt_st.rdata = {st_ff.bus_off, st_ff.ece, ctrl.power_down_enable || ctrl.sleep_mode, // RL23
                    st_ff.rx_success_flag, st_ff.tx_success_flag, st_ff.code};
    nxt_st.ece = ece_now; // RL6
    // bus-off entry and recovery sequence
    unique case (st_ff.mode)
      cse_pkg::CSE_ACTIVE: begin
        if (tx_err_count >= cse_pkg::TX_BUS_OFF_COUNT) begin
          nxt_st.mode = cse_pkg::CSE_RECOVERY; // RL25
          nxt_st.bus_off = 1'b1;
          nxt_st.sw_init = 1'b0;
          nxt_st.run_cnt = 4'h0;
          nxt_st.rec_cnt = 8'h00;
        end else if (st_ff.sw_init) begin
          nxt_st.mode = cse_pkg::CSE_INIT;
        end
      end
      cse_pkg::CSE_RECOVERY: begin
        if (recessive_bit) begin
          all_err.bit0_err = 1'b1; // RL22
          if (st_ff.run_cnt == cse_pkg::RECESSIVE_RUN - 4'h1) begin
            nxt_st.run_cnt = 4'h0;
            nxt_st.rec_cnt = 8'(st_ff.rec_cnt + 8'h01);
            if (st_ff.rec_cnt == cse_pkg::RECOVERY_RUNS - 8'h01) begin
              nxt_st.mode = cse_pkg::CSE_POWER_UP; // RL1
            end
          end else begin
            nxt_st.run_cnt = 4'(st_ff.run_cnt + 4'h1);
          end
        end else if (bus_s_ff.bit_tick) begin
          nxt_st.run_cnt = 4'h0;
        end
      end
      cse_pkg::CSE_POWER_UP: begin
        if (recessive_bit) begin
          if (st_ff.run_cnt == cse_pkg::RECESSIVE_RUN - 4'h1) begin
            nxt_st.mode = cse_pkg::CSE_INIT; // RL1 RL2
            nxt_st.bus_off = 1'b0;
            nxt_st.sw_init = 1'b1;
            nxt_st.cnt_clr = 1'b1; // RL5
            nxt_st.run_cnt = 4'h0;
          end else begin
            nxt_st.run_cnt = 4'(st_ff.run_cnt + 4'h1);
          end
        end else if (bus_s_ff.bit_tick) begin
          nxt_st.run_cnt = 4'h0;
        end
      end
      cse_pkg::CSE_INIT: begin
        if (!st_ff.sw_init) begin
          nxt_st.mode = cse_pkg::CSE_ACTIVE; // RL2
        end
      end
    endcase
    if (sw_init_wr && !st_ff.bus_off && st_ff.mode != cse_pkg::CSE_RECOVERY) begin
      nxt_st.sw_init = sw_init_wdata; // RL4
    end
    // sticky success flags: software writes first, hardware set wins
    if (status_wr) begin
      nxt_st.rx_success_flag = reg_wdata[cse_pkg::BIT_RXS];
      nxt_st.tx_success_flag = reg_wdata[cse_pkg::BIT_TXS];
    end
    if (rx_event) begin
      nxt_st.rx_success_flag = 1'b1; // RL8
    end
    if (tx_event) begin
      nxt_st.tx_success_flag = 1'b1; // RL15
    end
    // bus error code: read with init disabled forces 111b, new error only over 000b/111b
    if (status_rd && !st_ff.sw_init) begin
      nxt_st.code = cse_pkg::ERR_NO_CHANGE; // RL16
    end
    new_code = pick_code(all_err); // RL18
    if (new_code != cse_pkg::ERR_NONE &&
        (st_ff.code == cse_pkg::ERR_NONE || st_ff.code == cse_pkg::ERR_NO_CHANGE)) begin
      nxt_st.code = new_code; // RL17
    end
    // status-change interrupt; a read clears it, a new event re-raises it
    if (status_rd) begin
      nxt_st.stat_pend = 1'b0; // RL12
      nxt_st.err_pend = 1'b0;
    end
    // error interrupt after the read clear, so a same-cycle event is kept
    if (err_irq_on && ((nxt_st.bus_off && !st_ff.bus_off) || // RL3
        (ctrl.error_limit_select && (ece_now != st_ff.ece)) || // RL7
        (!ctrl.error_limit_select && ece_now && !st_ff.ece))) begin
      nxt_st.err_pend = 1'b1;
    end
    if (ctrl.status_irq_enable && (rx_event || tx_event || // RL11 RL13
        (status_wr && reg_wdata[cse_pkg::BIT_RXS] && !st_ff.rx_success_flag) || // RL14
        (status_wr && reg_wdata[cse_pkg::BIT_TXS] && !st_ff.tx_success_flag) ||
        (nxt_st.code != st_ff.code && nxt_st.code != cse_pkg::ERR_NONE &&
         nxt_st.code != cse_pkg::ERR_NO_CHANGE))) begin // RL24
      nxt_st.stat_pend = 1'b1;
    end
    if (channel_soft_reset) begin
      nxt_st.rx_success_flag = 1'b0; // RL8
      nxt_st.tx_success_flag = 1'b0;
      nxt_st.code = cse_pkg::ERR_NONE;
      nxt_st.stat_pend = 1'b0;
      nxt_st.err_pend = 1'b0;
      nxt_st.sw_init = 1'b1;
      nxt_st.cnt_clr = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{mode: cse_pkg::CSE_INIT, sw_init: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // indicator holds 01h while a status change or error interrupt is pending;
  // message centre sources only show once both are cleared
  assign irq_source_indicator = (st_ff.stat_pend || st_ff.err_pend) ? cse_pkg::IRQ_SRC_STATUS : msg_irq_source;
  assign can_irq = ctrl.channel_irq_enable && (irq_source_indicator != cse_pkg::IRQ_SRC_NONE);
  assign reg_rdata = st_ff.rdata;
  assign sw_init_enable = st_ff.sw_init;
  assign err_count_clear = st_ff.cnt_clr;
  assign bus_enable = (st_ff.mode == cse_pkg::CSE_ACTIVE) && !st_ff.bus_off; // RL25

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_busoff_exit: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL2
    ($fell(st_ff.bus_off) && !$past(channel_soft_reset)) |-> (st_ff.sw_init && err_count_clear))
    else $error("bus-off exit without init enable and counter clear");
  chk_busoff_entry: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL25
    (st_ff.mode == cse_pkg::CSE_ACTIVE && tx_err_count >= cse_pkg::TX_BUS_OFF_COUNT) |=> st_ff.bus_off)
    else $error("bus-off not set at tx count 256");
  chk_busoff_irq: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL3
    (err_irq_on && st_ff.mode == cse_pkg::CSE_ACTIVE && tx_err_count >= cse_pkg::TX_BUS_OFF_COUNT &&
     !channel_soft_reset) |=> irq_source_indicator == cse_pkg::IRQ_SRC_STATUS)
    else $error("bus-off entry raised no interrupt");
  chk_swinit_lock: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL4
    (st_ff.bus_off && sw_init_wr && !channel_soft_reset) |=> !st_ff.sw_init)
    else $error("sw init changed during bus-off");
  chk_recovery_len: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL1
    (st_ff.mode == cse_pkg::CSE_POWER_UP) |-> (st_ff.rec_cnt == cse_pkg::RECOVERY_RUNS))
    else $error("power-up entered before recovery runs done");
  chk_ece_limit: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
    (tx_err_count < 9'h060 && rx_err_count < 8'h60) |=> !st_ff.ece)
    else $error("exceeded flag set below limit");
  chk_rx_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
    (st_ff.rx_success_flag && !status_wr && !channel_soft_reset) |=> st_ff.rx_success_flag)
    else $error("rx success cleared without write");
  chk_status_irq: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL11
    (ctrl.status_irq_enable && tx_ok_acked && !channel_soft_reset) |=> irq_source_indicator == 8'h01)
    else $error("status interrupt not indicated");
  chk_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL12
    (status_rd && !rx_event && !tx_event && !status_wr && new_code == cse_pkg::ERR_NONE)
    |=> !st_ff.stat_pend)
    else $error("status read left interrupt pending");
  chk_code_lock: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL17
    (st_ff.code != 3'h0 && st_ff.code != 3'h7 && !status_rd && !channel_soft_reset) |=> $stable(st_ff.code))
    else $error("held error code overwritten");
  chk_code_rdclr: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL16
    (status_rd && !st_ff.sw_init && new_code == 3'h0 && !channel_soft_reset) |=> st_ff.code == 3'h7)
    else $error("status read did not force 111b");

endmodule : cse_status_unit

`default_nettype wire

// [testbench/cse_can_node.sv]
/*
  Stand-in for the other nodes on the CAN bus: bit-time ticks and the bus level.
  Assumes the bench clock drives it and nobody else drives bus_pin.
*/
`timescale 1ns/1ps
`default_nettype none

module cse_can_node (
  input wire logic clk_sys,
  output var cse_pkg::cse_bus_type bus_pin
);
  // --------------------------------------------------------------------
  // idle bus
  // --------------------------------------------------------------------
  // released bus sits recessive through the pull-up, no frame in flight
  initial begin
    bus_pin = '0;
    bus_pin.rx_bit = 1'b1;
    bus_pin.tx_bit = 1'b1;
  end

  // --------------------------------------------------------------------
  // recessive bit times
  // --------------------------------------------------------------------
  // one tick every four clocks keeps a bus-off recovery near 6k cycles
  task automatic send_recessive(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys) bus_pin.bit_tick <= 1'b1;
      @(posedge clk_sys) bus_pin.bit_tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask

  // --------------------------------------------------------------------
  // frames
  // --------------------------------------------------------------------
  // eight bits, first bit in the top position; tx is what our side sent
  task automatic send_frame(input logic [7:0] rx, input logic [7:0] tx, input logic txa, input logic arb);
    @(posedge clk_sys) begin
      bus_pin.rx_in_frame <= 1'b1;
      bus_pin.tx_active <= txa;
      bus_pin.in_arbitration <= arb;
    end
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_sys) begin
        bus_pin.bit_tick <= 1'b1;
        bus_pin.rx_bit <= rx[i];
        bus_pin.tx_bit <= tx[i];
      end
      @(posedge clk_sys) bus_pin.bit_tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    // back to an idle recessive bus so no run carries into the next frame
    @(posedge clk_sys) bus_pin <= '{rx_bit: 1'b1, tx_bit: 1'b1, default: 1'b0};
  endtask
endmodule // cse_can_node

`default_nettype wire

// [testbench/can_status_error_reporting_tb_top.sv]
/*
  Self-checking bench for the channel status unit: flags, codes, bus-off.
  Assumes cse_can_node supplies the bus samples; registers sit at 0xe4.
*/
`timescale 1ns/1ps
`default_nettype none

module can_status_error_reporting_tb_top;
  logic clk_sys, rst_b, reg_rd, reg_wr, sw_init_wr, sw_init_wdata, rx_ok, rx_stored, tx_ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_cnt, ind, d;
  logic [8:0] tx_cnt;
  logic sw_init_enable, err_count_clear, bus_enable, can_irq, soft_rst;
  cse_pkg::cse_ctrl_type ctrl;
  cse_pkg::cse_bus_type bus_pin;
  cse_pkg::cse_err_type frame_err;
  int errors = 0;
  int n_compared = 0;
  int n_clr = 0;
  logic [2:0] exp_code [6] = '{3'h5, 3'h1, 3'h6, 3'h3, 3'h2, 3'h4};

  cse_status_unit dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .channel_soft_reset(soft_rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sw_init_wr(sw_init_wr), .sw_init_wdata(sw_init_wdata),
    .sw_init_enable(sw_init_enable), .ctrl(ctrl), .bus_pin(bus_pin), .frame_err(frame_err),
    .rx_ok(rx_ok), .rx_stored(rx_stored), .tx_ok_acked(tx_ok), .tx_err_count(tx_cnt),
    .rx_err_count(rx_cnt), .err_count_clear(err_count_clear), .bus_enable(bus_enable),
    .msg_irq_source(8'h05), .irq_source_indicator(ind), .can_irq(can_irq));
  cse_can_node node_u (.clk_sys(clk_sys), .bus_pin(bus_pin));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // counters are outside the block: count the clear pulses it asks for
  always @(posedge clk_sys) if (err_count_clear) n_clr <= n_clr + 1;

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd();
    @(posedge clk_sys) reg_rd <= 1'b1;
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys) begin reg_addr <= a; reg_wr <= 1'b1; reg_wdata <= v; end
    @(posedge clk_sys) begin reg_addr <= 8'he4; reg_wr <= 1'b0; end
    #1;
  endtask
  task automatic perr(input cse_pkg::cse_err_type e);
    @(posedge clk_sys) frame_err <= e;
    @(posedge clk_sys) frame_err <= '0;
    #1;
  endtask
  task automatic prx(input logic st);
    @(posedge clk_sys) begin rx_ok <= 1'b1; rx_stored <= st; end
    @(posedge clk_sys) rx_ok <= 1'b0;
    #1;
  endtask
  task automatic sinit(input logic v);
    @(posedge clk_sys) begin sw_init_wr <= 1'b1; sw_init_wdata <= v; end
    @(posedge clk_sys) sw_init_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_flags();
    rd(); check(d, 8'h00);
    check({7'h0, sw_init_enable}, 8'h01);
    @(posedge clk_sys) tx_ok <= 1'b1;
    @(posedge clk_sys) tx_ok <= 1'b0;
    #1 check(ind, 8'h01);
    check({7'h0, can_irq}, 8'h01);
    rd(); check(d, 8'h08);
    check(ind, 8'h05);
    wr(8'he4, 8'h18); check(ind, 8'h01);
    rd(); check(d, 8'h18);
    wr(8'he4, 8'h18); check(ind, 8'h05);
    wr(8'he5, 8'h00); rd(); check(d, 8'h18);
    wr(8'he4, 8'h00); prx(1'b0); rd(); check(d, 8'h00);
    prx(1'b1); rd(); check(d, 8'h10);
    prx(1'b1); check(ind, 8'h01);
    wr(8'he4, 8'h00); ctrl.autobaud_mode <= 1'b1;
    prx(1'b0); rd(); check(d, 8'h10);
    ctrl.autobaud_mode <= 1'b0; ctrl.power_down_enable <= 1'b1;
    wr(8'he4, 8'h00); rd(); check(d, 8'h20);
    ctrl.power_down_enable <= 1'b0;
  endtask

  task automatic t_codes();
    sinit(1'b0); rd(); rd(); check(d, 8'h07);
    for (int i = 0; i < 6; i++) begin
      perr(6'b100000 >> i); check(ind, 8'h01);
      rd(); check(d, {5'h00, exp_code[i]});
      rd(); check(d, 8'h07);
    end
    perr(6'b000011); perr(6'b010000);
    rd(); check(d, 8'h02);
  endtask

  task automatic t_limit();
    rx_cnt <= 8'd95; rd(); rd(); check(d & 8'h40, 8'h00);
    rx_cnt <= 8'd96; rd(); rd(); check(d & 8'h40, 8'h40);
    ctrl.error_limit_select <= 1'b1; rd(); rd(); check(d & 8'h40, 8'h00);
    rx_cnt <= 8'd128; rd(); rd(); check(d & 8'h40, 8'h40);
    rx_cnt <= 8'd127; repeat (3) @(posedge clk_sys);
    #1 check(ind, 8'h01);
    rx_cnt <= 8'd0; rd(); rd();
  endtask

  task automatic t_busoff();
    tx_cnt <= 9'h100; rd(); rd(); check(d & 8'h80, 8'h80);
    check({7'h0, bus_enable}, 8'h00);
    sinit(1'b1); check({7'h0, sw_init_enable}, 8'h00);
    node_u.send_recessive(1410);
    rd(); check(d & 8'h87, 8'h85);
    node_u.send_recessive(40);
    for (int i = 0; i < 100 && sw_init_enable !== 1'b1; i++) @(posedge clk_sys);
    #1 check({7'h0, sw_init_enable}, 8'h01);
    check(n_clr[7:0], 8'h01);
    tx_cnt <= 9'h000;
    rd(); check(d & 8'h80, 8'h00);
    check({7'h0, bus_enable}, 8'h00);
    sinit(1'b0); check({7'h0, bus_enable}, 8'h01);
  endtask

  task automatic t_frames();
    node_u.send_frame(8'h03, 8'hff, 1'b0, 1'b0); rd(); check(d & 8'h07, 8'h01);
    node_u.send_frame(8'h04, 8'hff, 1'b0, 1'b0); rd(); check(d & 8'h07, 8'h07);
    node_u.send_frame(8'h55, 8'hff, 1'b1, 1'b1); rd(); check(d & 8'h07, 8'h07);
    node_u.send_frame(8'h55, 8'hff, 1'b1, 1'b0); rd(); check(d & 8'h07, 8'h04);
    node_u.send_frame(8'haa, 8'h00, 1'b1, 1'b0); rd(); check(d & 8'h07, 8'h05);
  endtask

  task automatic t_soft();
    wr(8'he4, 8'h18); check(ind, 8'h01);
    @(posedge clk_sys) soft_rst <= 1'b1;
    @(posedge clk_sys) soft_rst <= 1'b0;
    #1 check(ind, 8'h05);
    check({7'h0, sw_init_enable}, 8'h01);
    rd(); check(d, 8'h00);
  endtask

  initial begin
    rst_b = 1'b0; reg_rd = 1'b0; reg_wr = 1'b0; reg_addr = 8'he4; reg_wdata = 8'h00;
    sw_init_wr = 1'b0; sw_init_wdata = 1'b0; rx_ok = 1'b0; rx_stored = 1'b0; tx_ok = 1'b0;
    tx_cnt = 9'h000; rx_cnt = 8'h00; frame_err = '0; ctrl = 8'hf0; soft_rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_flags();
    t_codes();
    t_limit();
    t_frames();
    t_busoff();
    t_soft();
    print_verdict();
  end
endmodule // can_status_error_reporting_tb_top

`default_nettype wire
